// *** ccu_front.sv ***
// Purpose: pin front end of one unit: synchroniser, edge detect, edge prescaler
// Assumes: pin may change at any time relative to clk
// Notes: capture pulse lags the synchronised edge by one cycle
`include "ccu_params.svh"
`default_nettype none

module ccu_front (
   input wire logic clk,        // system clock
   input wire logic rst,        // async reset, active high
   ccu_front_if.front bus       // mode in, capture pulse out
);

   ccu_pkg::ccu_front_state_type s;
   ccu_pkg::ccu_front_state_type next_s;

   logic rise;
   logic fall;
   logic cap_mode;
   logic [3:0] mask;

   // edge detect looks at the second and third stage only
   assign rise = s.pin_sync & ~s.pin_prev;
   assign fall = ~s.pin_sync & s.pin_prev;
   assign cap_mode = (bus.mode[3:2] == `CCU_GRP_CAPTURE);
   assign mask = (bus.mode == `CCU_MODE_CAP_DIV4) ? `CCU_DIV4_MASK : `CCU_DIV16_MASK;

   // next state of the front end
   always_comb begin
      next_s = s;
      next_s.pin_meta = bus.pin_raw;
      next_s.pin_sync = s.pin_meta;
      next_s.pin_prev = s.pin_sync;
      next_s.capture = 1'b0;
      if (!cap_mode) begin
         next_s.pre_cnt = `CCU_PRE_ZERO;
      end else begin
         case (bus.mode)
            `CCU_MODE_CAP_FALL: begin
               next_s.capture = fall;
            end
            `CCU_MODE_CAP_RISE: begin
               next_s.capture = rise;
            end
            default: begin
               // count survives prescale switch, so a partial count can fire early
               if (rise) begin
                  if ((s.pre_cnt & mask) == mask) begin
                     next_s.capture = 1'b1;
                     next_s.pre_cnt = `CCU_PRE_ZERO;
                  end else begin
                     next_s.pre_cnt = s.pre_cnt + `CCU_PRE_ONE;
                  end
               end
            end
         endcase
      end
   end

   // state register; reset also clears the prescaler
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         next_s_reset: begin
            s <= '0;
         end
      end else begin
         s <= next_s;
      end
   end

   assign bus.capture = s.capture;

endmodule : ccu_front

`default_nettype wire

// *** ccu_front_if.sv ***
// Purpose: carries mode, raw pin and capture pulse between top and pin front end
// Assumes: single clock domain apart from the raw pin level
// Notes: capture is a one-cycle pulse from a flip-flop
`default_nettype none

interface ccu_front_if;
   logic [3:0] mode;   // current mode select
   logic pin_raw;      // unsynchronised pin level
   logic capture;      // capture event pulse

   modport owner (output mode, output pin_raw, input capture);
   modport front (input mode, input pin_raw, output capture);
endinterface : ccu_front_if

`default_nettype wire

// *** ccu_params.svh ***
// Purpose: offsets, field positions, codes and reset values of the capture/compare unit
// Assumes: included by the package and by the design modules
// Notes: definitions only
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

// register offsets on the plain register port
`define CCU_ADDR_W 8
`define CCU_DATA_W 8
`define CCU_OFS_CTRL_ONE 8'h17
`define CCU_OFS_CTRL_TWO 8'h1D
`define CCU_OFS_VAL_ONE_LOW 8'h40
`define CCU_OFS_VAL_ONE_HIGH 8'h41
`define CCU_OFS_VAL_TWO_LOW 8'h42
`define CCU_OFS_VAL_TWO_HIGH 8'h43
`define CCU_OFS_FLAGS 8'h44

// flag register bit positions
`define CCU_FLAG_ONE_BIT 2
`define CCU_FLAG_TWO_BIT 0

// control register fields
`define CCU_CTRL_WRITE_MASK 8'h3F
`define CCU_CTRL_RESET 8'h00
`define CCU_MODE_HI 3
`define CCU_MODE_LO 0

// mode codes
`define CCU_MODE_OFF 4'h0
`define CCU_MODE_CAP_FALL 4'h4
`define CCU_MODE_CAP_RISE 4'h5
`define CCU_MODE_CAP_DIV4 4'h6
`define CCU_MODE_CAP_DIV16 4'h7
`define CCU_MODE_CMP_SET 4'h8
`define CCU_MODE_CMP_CLEAR 4'h9
`define CCU_MODE_CMP_SOFT 4'hA
`define CCU_MODE_CMP_TRIG 4'hB

// mode groups by the upper two bits
`define CCU_GRP_OFF 2'h0
`define CCU_GRP_CAPTURE 2'h1
`define CCU_GRP_COMPARE 2'h2
`define CCU_GRP_PWM 2'h3

// edge prescaler terminal masks
`define CCU_DIV4_MASK 4'h3
`define CCU_DIV16_MASK 4'hF
`define CCU_PRE_ZERO 4'h0
`define CCU_PRE_ONE 4'h1

// misc widths, unit count and unit index
`define CCU_TIMER_W 16
`define CCU_UNITS 2
`define CCU_UNIT_TWO 1

`endif

// *** ccu_pin_model.sv ***
// Purpose: external event source on the unit one pin
// Assumes: pulses are spaced far beyond the synchroniser depth
// Notes: pin idles low between pulses
`default_nettype none

module ccu_pin_model (
   input wire logic clk,  // bench clock
   output logic pin       // event pin level
);
   timeunit 1ns;
   timeprecision 1ps;

   // pin starts idle low
   initial pin = 1'b0;

   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         pin <= 1'b1;
         repeat (3) @(posedge clk);
         pin <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask : pulses
endmodule : ccu_pin_model

`default_nettype wire

// *** ccu_pkg.sv ***
// Purpose: state types of the capture/compare unit
// Assumes: ccu_params.svh supplies the widths
// Notes: one packed struct per module holds all of its state
`include "ccu_params.svh"
`default_nettype none

package ccu_pkg;

   // pin front end: synchroniser, edge history, prescaler
   typedef struct packed {
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
      logic [3:0] pre_cnt;
      logic capture;
   } ccu_front_state_type;

   // register file and per-unit compare/capture state
   typedef struct packed {
      logic [`CCU_UNITS-1:0][`CCU_DATA_W-1:0] ctrl;
      logic [`CCU_UNITS-1:0][`CCU_TIMER_W-1:0] value;
      logic [`CCU_UNITS-1:0] flag;
      logic [`CCU_UNITS-1:0] out_latch;
      logic [`CCU_UNITS-1:0] match_prev;
      logic [`CCU_UNITS-1:0] pwm_active;
      logic [`CCU_DATA_W-1:0] rd_data;
      logic timer_reset;
      logic adc_start;
   } ccu_top_state_type;

endpackage : ccu_pkg

`default_nettype wire

// *** ccu_top.sv ***
// Purpose: two capture/compare units against an external 16-bit timer
// Assumes: timer count and adc enable come from logic on clk; unit pins are asynchronous
// Notes: registers sit on a plain byte-wide port with read data one cycle after the strobe
//
// What this block does
// - mode 0000 switches the unit off and resets its internal state
// - modes 0100-0111 capture on fall, rise, every 4th or 16th rise
// - 1000 drives pin high, 1001 low on match; both set the flag
// - 1010 leaves pin alone on match and only sets the flag
// - 1011 sets flag, resets timer; unit two also starts enabled converter
// - capture copies the full 16-bit timer count into the value register
// - every capture sets the unit flag, bit 2 for unit one
// - new capture overwrites an unread value with no overrun sign
// - mode change may raise a false capture flag; software clears it
// - prescaler cleared when off, not capturing, or on reset
// - switching prescale settings keeps the prescaler count
// - compare mode checks value register against timer count for equality
// - flag and pin action take effect in the same cycle
// - timer reset from a trigger does not raise the overflow flag
// - writing zero to control forces the compare output latch low
`include "ccu_params.svh"
`default_nettype none

module ccu_top (
   input wire logic clk,                              // system clock, 100 MHz
   input wire logic rst,                              // async reset, active high
   input wire logic [`CCU_ADDR_W-1:0] addr,           // register address
   input wire logic [`CCU_DATA_W-1:0] wr_data,        // register write data
   input wire logic wr_en,                            // write strobe
   input wire logic rd_en,                            // read strobe
   output logic [`CCU_DATA_W-1:0] rd_data,            // read data, cycle after rd_en
   input wire logic [`CCU_TIMER_W-1:0] timer_count,   // free-running timer count
   input wire logic adc_enabled,                      // converter is enabled
   input wire logic [`CCU_UNITS-1:0] unit_pin_in,     // pin levels, asynchronous
   output logic [`CCU_UNITS-1:0] unit_pin_out,        // compare output latches
   output logic [`CCU_UNITS-1:0] pwm_active,          // unit in pwm mode
   output logic timer_reset,                          // special event timer clear pulse
   output logic adc_start                             // special event conversion start pulse
);

   ccu_pkg::ccu_top_state_type s;
   ccu_pkg::ccu_top_state_type next_s;

   logic [`CCU_UNITS-1:0] capture_evt;
   logic [`CCU_UNITS-1:0][3:0] mode;

   // one pin front end per unit
   ccu_front_if front_bus[`CCU_UNITS] ();

   genvar gi;
   generate
      for (gi = 0; gi < `CCU_UNITS; gi = gi + 1) begin : g_unit
         assign mode[gi] = s.ctrl[gi][`CCU_MODE_HI:`CCU_MODE_LO];
         assign front_bus[gi].mode = mode[gi];
         assign front_bus[gi].pin_raw = unit_pin_in[gi];
         assign capture_evt[gi] = front_bus[gi].capture;

         ccu_front u_front (
            .clk(clk),
            .rst(rst),
            .bus(front_bus[gi])
         );
      end
   endgenerate

   // flag bits as software sees them
   function automatic logic [`CCU_DATA_W-1:0] flag_image(input logic [`CCU_UNITS-1:0] f);
      logic [`CCU_DATA_W-1:0] img;
      img = '0;
      img[`CCU_FLAG_ONE_BIT] = f[0];
      img[`CCU_FLAG_TWO_BIT] = f[1];
      return img;
   endfunction : flag_image

   // next state: register writes first, hardware events on top
   always_comb begin
      logic grp_cap;
      logic grp_cmp;
      logic match;
      logic hit;
      grp_cap = 1'b0;
      grp_cmp = 1'b0;
      match = 1'b0;
      hit = 1'b0;
      next_s = s;
      next_s.timer_reset = 1'b0;
      next_s.adc_start = 1'b0;

      // software writes
      if (wr_en) begin
         case (addr)
            `CCU_OFS_CTRL_ONE: begin
               next_s.ctrl[0] = wr_data & `CCU_CTRL_WRITE_MASK;
            end
            `CCU_OFS_CTRL_TWO: begin
               next_s.ctrl[1] = wr_data & `CCU_CTRL_WRITE_MASK;
            end
            `CCU_OFS_VAL_ONE_LOW: begin
               next_s.value[0][7:0] = wr_data;
            end
            `CCU_OFS_VAL_ONE_HIGH: begin
               next_s.value[0][15:8] = wr_data;
            end
            `CCU_OFS_VAL_TWO_LOW: begin
               next_s.value[1][7:0] = wr_data;
            end
            `CCU_OFS_VAL_TWO_HIGH: begin
               next_s.value[1][15:8] = wr_data;
            end
            `CCU_OFS_FLAGS: begin
               next_s.flag[0] = wr_data[`CCU_FLAG_ONE_BIT];
               next_s.flag[1] = wr_data[`CCU_FLAG_TWO_BIT];
            end
            default: begin
            end
         endcase
      end

      // per-unit capture and compare behaviour
      for (int i = 0; i < `CCU_UNITS; i++) begin
         grp_cap = (mode[i][3:2] == `CCU_GRP_CAPTURE);
         grp_cmp = (mode[i][3:2] == `CCU_GRP_COMPARE);

         match = grp_cmp && (timer_count == s.value[i]);
         // a stalled timer would match for many cycles; act once per match
         hit = match && !s.match_prev[i];
         next_s.match_prev[i] = match;

         next_s.pwm_active[i] = (mode[i][3:2] == `CCU_GRP_PWM);

         if (mode[i] == `CCU_MODE_OFF) begin
            next_s.out_latch[i] = 1'b0;
            next_s.match_prev[i] = 1'b0;
         end

         if (grp_cap && capture_evt[i]) begin
            next_s.value[i] = timer_count;
            next_s.flag[i] = 1'b1;
         end

         if (hit) begin
            next_s.flag[i] = 1'b1;
            case (mode[i])
               `CCU_MODE_CMP_SET: begin
                  next_s.out_latch[i] = 1'b1;
               end
               `CCU_MODE_CMP_CLEAR: begin
                  next_s.out_latch[i] = 1'b0;
               end
               `CCU_MODE_CMP_SOFT: begin
                  next_s.out_latch[i] = s.out_latch[i];
               end
               `CCU_MODE_CMP_TRIG: begin
                  next_s.timer_reset = 1'b1;
                  if (i == `CCU_UNIT_TWO) begin
                     next_s.adc_start = adc_enabled;
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // read data stands for exactly the cycle after the strobe
      next_s.rd_data = '0;
      if (rd_en) begin
         case (addr)
            `CCU_OFS_CTRL_ONE: begin
               next_s.rd_data = s.ctrl[0];
            end
            `CCU_OFS_CTRL_TWO: begin
               next_s.rd_data = s.ctrl[1];
            end
            `CCU_OFS_VAL_ONE_LOW: begin
               next_s.rd_data = s.value[0][7:0];
            end
            `CCU_OFS_VAL_ONE_HIGH: begin
               next_s.rd_data = s.value[0][15:8];
            end
            `CCU_OFS_VAL_TWO_LOW: begin
               next_s.rd_data = s.value[1][7:0];
            end
            `CCU_OFS_VAL_TWO_HIGH: begin
               next_s.rd_data = s.value[1][15:8];
            end
            `CCU_OFS_FLAGS: begin
               next_s.rd_data = flag_image(s.flag);
            end
            default: begin
               next_s.rd_data = '0;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state flops
   assign rd_data = s.rd_data;
   assign unit_pin_out = s.out_latch;
   assign pwm_active = s.pwm_active;
   assign timer_reset = s.timer_reset;
   assign adc_start = s.adc_start;

endmodule : ccu_top

`default_nettype wire

// *** ccu_top_asserts.sv ***
// Purpose: port checks of the capture/compare unit
// Assumes: one clock, rst async active high
// Notes: mirrors the written mode fields to judge pin and trigger outputs
`include "ccu_params.svh"
`default_nettype none

module ccu_top_asserts (
   input wire logic clk,                 // clock
   input wire logic rst,                 // reset
   input wire logic [7:0] addr,          // address
   input wire logic [7:0] wr_data,       // write data
   input wire logic wr_en,               // write strobe
   input wire logic adc_enabled,         // converter on
   input wire logic [1:0] unit_pin_out,  // output latches
   input wire logic [1:0] pwm_active,    // pwm flags
   input wire logic timer_reset,         // trigger pulse
   input wire logic adc_start            // conversion pulse
);
   logic [3:0] m1;
   logic [3:0] m2;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // mode mirrors land on the same edge as the design's control registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         m1 <= 4'h0;
         m2 <= 4'h0;
      end else if (wr_en && addr == `CCU_OFS_CTRL_ONE) begin
         m1 <= wr_data[3:0];
      end else if (wr_en && addr == `CCU_OFS_CTRL_TWO) begin
         m2 <= wr_data[3:0];
      end
   end

   AST_PIN_SET: assert property ($rose(unit_pin_out[0]) |-> $past(m1) == 4'h8)
      else $error("pin one rose outside set mode");
   AST_PIN_CLR: assert property ($fell(unit_pin_out[0]) |-> $past(m1) == 4'h9 || $past(m1) == 4'h0)
      else $error("pin one fell outside clear or off mode");
   AST_PIN_KEEP: assert property ($past(m1) inside {4'hA, 4'hB} |-> $stable(unit_pin_out[0]))
      else $error("pin one moved in a pin-neutral mode");
   AST_OFF_LOW: assert property ($past(m1) == 4'h0 |-> !unit_pin_out[0])
      else $error("pin one latch not low while off");
   AST_TRIG_CAUSE: assert property (timer_reset |-> $past(m1) == 4'hB || $past(m2) == 4'hB)
      else $error("timer clear without trigger mode");
   AST_ADC_CAUSE: assert property (adc_start |-> timer_reset && $past(m2) == 4'hB && $past(adc_enabled))
      else $error("conversion start without unit two trigger");
   AST_ADC_GO: assert property (timer_reset && $past(m2) == 4'hB && $past(m1) != 4'hB && $past(adc_enabled)
      |-> adc_start)
      else $error("unit two trigger did not start conversion");
   AST_PWM: assert property (m1 == $past(m1) |-> pwm_active[0] == (m1[3:2] == 2'h3))
      else $error("pwm flag disagrees with mode");
   AST_PWM_TWO: assert property (m2 == $past(m2) |-> pwm_active[1] == (m2[3:2] == 2'h3))
      else $error("unit two pwm flag disagrees with mode");
endmodule : ccu_top_asserts

`default_nettype wire

// *** ccu_top_tb.sv ***
// Purpose: self-checking bench of the capture/compare unit
// Assumes: timer modelled here, synchronous to clk
// Notes: captures run with the timer frozen so the stored value is exact
`include "ccu_params.svh"
`default_nettype none

module ccu_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, wr_en, rd_en, run, adc_enabled, pin, trig, adc;
   logic [7:0] addr, wr_data, rd_data;
   logic [15:0] tmr;
   logic [1:0] pin_out, pwm;
   int n_fail, checks_done, n_trig, n_adc;

   ccu_top u_ccu_top (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .timer_count(tmr), .adc_enabled(adc_enabled), .unit_pin_in({1'b0, pin}),
      .unit_pin_out(pin_out), .pwm_active(pwm), .timer_reset(trig), .adc_start(adc));
   ccu_pin_model u_ccu_pin_model (.clk(clk), .pin(pin));

   // free clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (trig) begin
         tmr <= 16'h0000;
         n_trig++;
      end else if (run) begin
         tmr <= tmr + 16'h0001;
      end
      if (adc) begin
         n_adc++;
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   // read data is taken at the edge closing its one valid cycle
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      chk(what, {8'h00, exp}, {8'h00, rd_data});
   endtask : rchk

   task automatic t_regs();
      rchk("ctrl one", `CCU_OFS_CTRL_ONE, 8'h00);
      wr(`CCU_OFS_CTRL_TWO, 8'hF0);
      rchk("ctrl two", `CCU_OFS_CTRL_TWO, 8'h30);
      rchk("unmapped", 8'h99, 8'h00);
      wr(`CCU_OFS_CTRL_TWO, 8'h0C);
      repeat (2) @(posedge clk);
      chk("pwm two", 16'h0001, {15'h0000, pwm[1]});
      wr(`CCU_OFS_CTRL_TWO, 8'h00);
   endtask : t_regs

   task automatic t_cap();
      logic [3:0] modes [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
      int need [4] = '{1, 1, 4, 16};
      logic [15:0] k;
      for (int i = 0; i < 4; i++) begin
         k = 16'hA5C3 + 16'(i * 273);
         @(posedge clk);
         tmr <= k;
         wr(`CCU_OFS_CTRL_ONE, 8'h00);
         wr(`CCU_OFS_CTRL_ONE, {4'h0, modes[i]});
         wr(`CCU_OFS_FLAGS, 8'h00);
         u_ccu_pin_model.pulses(need[i] - 1);
         rchk("early flag", `CCU_OFS_FLAGS, 8'h00);
         u_ccu_pin_model.pulses(1);
         repeat (4) @(posedge clk);
         rchk("capture flag", `CCU_OFS_FLAGS, 8'h04);
         rchk("value low", `CCU_OFS_VAL_ONE_LOW, k[7:0]);
         rchk("value high", `CCU_OFS_VAL_ONE_HIGH, k[15:8]);
      end
      wr(`CCU_OFS_CTRL_ONE, 8'h05);
      @(posedge clk);
      tmr <= 16'h0F1E;
      u_ccu_pin_model.pulses(1);
      @(posedge clk);
      tmr <= 16'h7E81;
      u_ccu_pin_model.pulses(1);
      repeat (4) @(posedge clk);
      rchk("newer low", `CCU_OFS_VAL_ONE_LOW, 8'h81);
      rchk("newer high", `CCU_OFS_VAL_ONE_HIGH, 8'h7E);
   endtask : t_cap

   // one pass of the timer across 1234h with the unit in mode m
   task automatic t_cmp(input int u, input logic [3:0] m, input logic pe, input int te, input int ae);
      wr(`CCU_OFS_VAL_ONE_LOW + 8'(2 * u), 8'h34);
      wr(`CCU_OFS_VAL_ONE_HIGH + 8'(2 * u), 8'h12);
      wr((u == 0) ? `CCU_OFS_CTRL_ONE : `CCU_OFS_CTRL_TWO, {4'h0, m});
      wr(`CCU_OFS_FLAGS, 8'h00);
      @(posedge clk);
      tmr <= 16'h1230;
      run <= 1'b1;
      repeat (12) @(posedge clk);
      run <= 1'b0;
      rchk("compare flag", `CCU_OFS_FLAGS, (u == 0) ? 8'h04 : 8'h01);
      chk("pin", {15'h0000, pe}, {15'h0000, pin_out[u]});
      chk("timer clears", 16'(te), 16'(n_trig));
      chk("conversions", 16'(ae), 16'(n_adc));
   endtask : t_cmp

   // main sequence
   initial begin
      rst = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
      run = 1'b0;
      adc_enabled = 1'b0;
      tmr = 16'hFFFF;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_cap();
      t_cmp(0, 4'h8, 1'b1, 0, 0);
      t_cmp(0, 4'hA, 1'b1, 0, 0);
      t_cmp(0, 4'h9, 1'b0, 0, 0);
      t_cmp(0, 4'h8, 1'b1, 0, 0);
      t_cmp(0, 4'hB, 1'b1, 1, 0);
      wr(`CCU_OFS_CTRL_ONE, 8'h00);
      repeat (2) @(posedge clk);
      chk("pin off", 16'h0000, {15'h0000, pin_out[0]});
      adc_enabled <= 1'b1;
      t_cmp(1, 4'hB, 1'b0, 2, 1);
      final_report();
   end

   // watchdog
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule : ccu_top_tb

bind ccu_top ccu_top_asserts u_ccu_top_asserts (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
   .wr_en(wr_en), .adc_enabled(adc_enabled), .unit_pin_out(unit_pin_out), .pwm_active(pwm_active),
   .timer_reset(timer_reset), .adc_start(adc_start));

`default_nettype wire
